// ---- inc/ulsbg_consts.svh ----
`ifndef ULSBG_CONSTS_SVH
`define ULSBG_CONSTS_SVH
// register indices; byte address is four times the index
`define ULSBG_IDX_DIVLO      4'h0
`define ULSBG_IDX_DIVHI      4'h1
`define ULSBG_IDX_LINE       4'h5
`define ULSBG_IDX_MODEM      4'h6
`define ULSBG_IDX_SCRATCH    4'h7
`define ULSBG_IDX_CFG        4'h8
// line state field positions
`define ULSBG_LINE_RX_READY  0
`define ULSBG_LINE_OVERRUN   1
`define ULSBG_LINE_PARITY    2
`define ULSBG_LINE_STOP      3
`define ULSBG_LINE_BREAK     4
`define ULSBG_LINE_HOLD_MT   5
`define ULSBG_LINE_ALL_MT    6
`define ULSBG_LINE_ERR_SUM   7
// config register fields
`define ULSBG_CFG_FIFO       0
`define ULSBG_CFG_SEL_LO     1
`define ULSBG_CFG_SEL_HI     2
// reset values
`define ULSBG_DIV_RST        16'h000c
`define ULSBG_SCRATCH_RST    8'h00
`define ULSBG_CFG_RST        3'h0
// queue depths and timing in 16x ticks
`define ULSBG_FIFO_DEPTH     5'h10
`define ULSBG_BUF_DEPTH      5'h01
`define ULSBG_HALF_BIT_TICKS 8'h08
`define ULSBG_DEAD_DIV       16'h0003
// phase steps: f_out * 2^24 / 50 MHz
`define ULSBG_STEP_18462     24'h0973d9
`define ULSBG_STEP_18432     24'h096feb
`define ULSBG_STEP_36864     24'h12dfd7
`define ULSBG_STEP_73728     24'h25bfad
`endif

// ---- inc/ulsbg_pkg.sv ----
package ulsbg_pkg;
  // break watcher states
  typedef enum logic [1:0] {
    BRK_IDLE = 2'b00,
    BRK_LOW  = 2'b01,
    BRK_WAIT = 2'b10
  } ulsbg_brk_t;
  typedef logic [2:0] ulsbg_err_t; // {break, framing, parity}
endpackage : ulsbg_pkg

// ---- hw/ulsbg_top.sv ----
// Local design decision: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "ulsbg_consts.svh"
// Functional notes
// - data-ready set when a character lands; clears once all data read
// - buffer mode overrun sets on unread replacement, clears on status read
// - queue mode overrun only when full; lost character never queued
// - parity error flag sets on bad parity, clears on status read
// - queue mode keeps errors per character, shown at queue head
// - framing error sets on zero stop bit, clears on status read
// - after framing error receiver resyncs treating stop bit as start
// - break flag sets when input low beyond one frame time
// - one all-zero character is queued per break
// - receiver restarts only after half a bit time of idle high
// - any receive error raises line status interrupt when enabled
// - holding-empty sets on move to shifter, clears on CPU write
// - queue mode holding-empty while transmit queue empty
// - transmitter-empty only when holding and shift registers empty
// - bit 7 zero in buffer mode; queue error summary in queue mode
// - modem state register always reads zero
// - scratch byte is read/write with no effect on operation
// - divider by 1..65535 gives sixteen times bit rate
// - two divisor bytes; writing either reloads the counter
// - divider waveform per divisor 0, 1, 2 and three or more
// - divider input rate chosen among four derived frequencies
module ulsbg_top
  import ulsbg_pkg::*;
(
  input  wire logic        MCLK_IN,          // 50 MHz clock
  input  wire logic        NRST_IN,          // async reset, low
  input  wire logic        PSEL_IN,          // apb select
  input  wire logic        PENABLE_IN,       // apb enable
  input  wire logic        PWRITE_IN,        // apb direction
  input  wire logic [7:0]  PADDR_IN,         // apb byte address
  input  wire logic [31:0] PWDATA_IN,        // apb write data
  output logic      [31:0] PRDATA_OUT,       // apb read data
  output logic             PREADY_OUT,       // apb ready
  output logic             PSLVERR_OUT,      // apb error
  input  wire logic        RXD_IN,           // serial input pin
  input  wire logic        DIV_ACCESS_IN,    // divisor access select
  input  wire logic [1:0]  WORD_LEN_IN,      // data bits minus 5
  input  wire logic        PARITY_EN_IN,     // parity bit present
  input  wire logic        RLS_IE_IN,        // line status irq enable
  input  wire logic        TXE_IE_IN,        // holding empty irq enable
  input  wire logic        RX_CHAR_DONE_IN,  // character complete
  input  wire logic        RX_PERR_IN,       // its parity bad
  input  wire logic        RX_FERR_IN,       // its stop bit zero
  input  wire logic        RX_POP_IN,        // cpu read of rx data
  input  wire logic        TX_WRITE_IN,      // cpu write of tx data
  input  wire logic        TX_MOVE_IN,       // holding to shifter
  input  wire logic        TX_SHIFT_BUSY_IN, // shifter holds a char
  output logic             RX_PUSH_OUT,      // store char in rx data
  output logic             RX_ZERO_LOAD_OUT, // store zero char
  output logic             RX_RESYNC_OUT,    // treat stop as start
  output logic             RX_ENABLE_OUT,    // receiver may start
  output logic             FIFO_MODE_OUT,    // queue mode on
  output logic             BAUD_TICK_OUT,    // 16x enable pulse
  output logic             BAUD_LEVEL_OUT,   // 16x waveform
  output logic             RLS_IRQ_OUT,      // line status request
  output logic             TXE_IRQ_OUT       // holding empty request
);

  logic             rst_q1, rst_n;
  logic             rx_q1, rx_s;
  logic [15:0]      div, next_div;
  logic [7:0]       scratch, next_scratch;
  logic [2:0]       cfg, next_cfg;
  logic [31:0]      next_prdata;
  logic             next_pready, next_pslverr;
  logic [3:0]       idx;
  logic             hit, acc, line_rd, div_wr;
  logic [7:0]       line_val;
  ulsbg_err_t       mem [0:15];
  logic [3:0]       rd_p, wr_p, next_rd_p, next_wr_p;
  logic [4:0]       cnt, next_cnt, depth;
  logic             seen, next_seen, ovr, next_ovr;
  logic             err_any, next_err_any;
  logic             load, push, pop, ovr_set, mem_we;
  ulsbg_err_t       load_err, head;
  logic [15:0]      remain;
  logic [4:0]       tcnt, next_tcnt;
  logic             tx_holding_empty, tx_all_empty;
  logic [23:0]      nco, next_nco, step;
  logic             ntick, next_ntick;
  logic [15:0]      per, bcnt, next_bcnt;
  logic             next_level, next_btick;
  ulsbg_brk_t       brk_st, next_brk_st;
  logic [7:0]       brk_cnt, next_brk_cnt, limit;
  logic [3:0]       bits;
  logic             brk_load;

  // reset release and pin synchroniser
  always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
      rx_q1  <= 1'b1;
      rx_s   <= 1'b1;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
      rx_q1  <= RXD_IN;
      rx_s   <= rx_q1;
    end
  end

  // bus decode; unmapped or latch without access select errors
  assign idx     = PADDR_IN[5:2];
  assign hit     = (PADDR_IN[7:6] == 2'b00) && (PADDR_IN[1:0] == 2'b00)
                 && ((idx >= `ULSBG_IDX_LINE && idx <= `ULSBG_IDX_CFG)
                 || (DIV_ACCESS_IN && idx <= `ULSBG_IDX_DIVHI));
  assign acc     = PSEL_IN && PENABLE_IN && PREADY_OUT;
  assign line_rd = acc && !PWRITE_IN && hit && idx == `ULSBG_IDX_LINE;
  assign div_wr  = acc && PWRITE_IN && hit && idx <= `ULSBG_IDX_DIVHI;

  // status byte seen by software
  assign line_val = {err_any, tx_all_empty, tx_holding_empty,
                     (cnt != 5'h00 && !seen) ? head : 3'h0, ovr,
                     cnt != 5'h00};

  // register writes and read data; status writes are dropped
  always_comb begin
    next_div     = div;
    next_scratch = scratch;
    next_cfg     = cfg;
    next_pready  = PSEL_IN && !PENABLE_IN;
    next_pslverr = PSEL_IN && !PENABLE_IN && !hit;
    next_prdata  = 32'h0000_0000;
    if (PSEL_IN && !PENABLE_IN && hit && !PWRITE_IN) begin
      case (idx)
        `ULSBG_IDX_DIVLO:   next_prdata = {24'h0, div[7:0]};
        `ULSBG_IDX_DIVHI:   next_prdata = {24'h0, div[15:8]};
        `ULSBG_IDX_LINE:    next_prdata = {24'h0, line_val};
        `ULSBG_IDX_SCRATCH: next_prdata = {24'h0, scratch};
        `ULSBG_IDX_CFG:     next_prdata = {29'h0, cfg};
        default:            next_prdata = 32'h0000_0000;
      endcase
    end
    if (acc && PWRITE_IN && hit) begin
      case (idx)
        `ULSBG_IDX_DIVLO:   next_div[7:0]  = PWDATA_IN[7:0];
        `ULSBG_IDX_DIVHI:   next_div[15:8] = PWDATA_IN[7:0];
        `ULSBG_IDX_SCRATCH: next_scratch = PWDATA_IN[7:0];
        `ULSBG_IDX_CFG:     next_cfg = PWDATA_IN[2:0];
        default:            next_scratch = scratch;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      div         <= `ULSBG_DIV_RST;
      scratch     <= `ULSBG_SCRATCH_RST;
      cfg         <= `ULSBG_CFG_RST;
      PRDATA_OUT  <= 32'h0000_0000;
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      div         <= next_div;
      scratch     <= next_scratch;
      cfg         <= next_cfg;
      PRDATA_OUT  <= next_prdata;
      PREADY_OUT  <= next_pready;
      PSLVERR_OUT <= next_pslverr;
    end
  end

  // per-entry error still queued, for the queue error summary
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_ent
      logic [3:0] ofs;
      assign ofs = 4'(gi) - rd_p;
      assign remain[gi] = ({1'b0, ofs} < cnt) && (mem[gi] != 3'h0);
    end
  endgenerate

  // receive error queue, one entry per stored character
  assign depth    = cfg[`ULSBG_CFG_FIFO] ? `ULSBG_FIFO_DEPTH
                                         : `ULSBG_BUF_DEPTH;
  assign head     = mem[rd_p];
  assign load     = RX_CHAR_DONE_IN || brk_load;
  assign load_err = brk_load ? 3'h4 : {1'b0, RX_FERR_IN, RX_PERR_IN};
  always_comb begin
    pop       = RX_POP_IN && cnt != 5'h00;
    push      = 1'b0;
    mem_we    = 1'b0;
    ovr_set   = 1'b0;
    next_rd_p = rd_p;
    next_wr_p = wr_p;
    next_cnt  = cnt;
    next_seen = seen;
    if (load) begin
      if (!cfg[`ULSBG_CFG_FIFO]) begin
        ovr_set = cnt != 5'h00 && !pop;
        push    = 1'b1;
        mem_we  = 1'b1;
      end else if (cnt == depth && !pop) begin
        ovr_set = 1'b1;
      end else begin
        push    = 1'b1;
        mem_we  = 1'b1;
      end
    end
    if (cfg[`ULSBG_CFG_FIFO]) begin
      next_cnt  = cnt + 5'(push) - 5'(pop);
      next_wr_p = wr_p + 4'(push);
      next_rd_p = rd_p + 4'(pop);
    end else begin
      next_cnt  = push ? 5'h01 : (pop ? 5'h00 : cnt);
    end
    // new head wins over a status read in the same cycle
    if (line_rd)
      next_seen = 1'b1;
    if (pop || (push && (cnt == 5'h00 || !cfg[`ULSBG_CFG_FIFO])))
      next_seen = 1'b0;
    next_ovr = ovr_set || (ovr && !line_rd);
    next_err_any = cfg[`ULSBG_CFG_FIFO] && ((push && load_err != 3'h0)
                || (err_any && !(line_rd && remain == 16'h0)));
  end

  always_ff @(posedge MCLK_IN) begin
    if (mem_we)
      mem[wr_p] <= load_err;
  end

  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      rd_p    <= 4'h0;
      wr_p    <= 4'h0;
      cnt     <= 5'h00;
      seen    <= 1'b0;
      ovr     <= 1'b0;
      err_any <= 1'b0;
    end else begin
      rd_p    <= next_rd_p;
      wr_p    <= next_wr_p;
      cnt     <= next_cnt;
      seen    <= next_seen;
      ovr     <= next_ovr;
      err_any <= next_err_any;
    end
  end

  // transmit occupancy; write and move both count in the same cycle, except a write when full or a move when empty
  assign tx_holding_empty = tcnt == 5'h00;
  assign tx_all_empty     = tx_holding_empty && !TX_SHIFT_BUSY_IN;
  always_comb begin
    next_tcnt = tcnt + 5'(TX_WRITE_IN && tcnt < depth)
                     - 5'(TX_MOVE_IN && tcnt != 5'h00);
  end

  // phase accumulator stands in for the derived input clock
  always_comb begin
    case (cfg[`ULSBG_CFG_SEL_HI:`ULSBG_CFG_SEL_LO])
      2'h1:    step = `ULSBG_STEP_18432;
      2'h2:    step = `ULSBG_STEP_36864;
      2'h3:    step = `ULSBG_STEP_73728;
      default: step = `ULSBG_STEP_18462;
    endcase
    {next_ntick, next_nco} = {1'b0, nco} + {1'b0, step};
  end

  // divider; a latch write reloads so no long first count
  assign per = (div == 16'h0000) ? `ULSBG_DEAD_DIV : div;
  always_comb begin
    next_bcnt  = bcnt;
    next_btick = 1'b0;
    next_level = BAUD_LEVEL_OUT;
    if (div_wr) begin
      next_bcnt  = 16'hffff;
    end else if (ntick) begin
      next_btick = bcnt == 16'h0000 || bcnt >= per;
      next_bcnt  = next_btick ? per - 16'h0001 : bcnt - 16'h0001;
      if (per == 16'h0001)
        next_level = !BAUD_LEVEL_OUT;
      else if (per == 16'h0002)
        next_level = next_bcnt != 16'h0001;
      else
        next_level = next_bcnt < per - 16'h0002;
    end
  end

  // break watcher on the synchronised line, in 16x ticks
  assign bits  = 4'h7 + {2'b00, WORD_LEN_IN} + {3'b000, PARITY_EN_IN};
  assign limit = {bits, 4'h0};
  always_comb begin
    next_brk_st  = brk_st;
    next_brk_cnt = brk_cnt;
    brk_load     = 1'b0;
    case (brk_st)
      BRK_IDLE: begin
        next_brk_cnt = 8'h00;
        if (!rx_s)
          next_brk_st = BRK_LOW;
      end
      BRK_LOW: begin
        if (rx_s)
          next_brk_st = BRK_IDLE;
        else if (BAUD_TICK_OUT && brk_cnt >= limit) begin
          brk_load     = 1'b1;
          next_brk_cnt = 8'h00;
          next_brk_st  = BRK_WAIT;
        end else if (BAUD_TICK_OUT)
          next_brk_cnt = brk_cnt + 8'h01;
      end
      BRK_WAIT: begin
        if (!rx_s)
          next_brk_cnt = 8'h00;
        else if (BAUD_TICK_OUT
                 && brk_cnt == `ULSBG_HALF_BIT_TICKS - 8'h01)
          next_brk_st = BRK_IDLE;
        else if (BAUD_TICK_OUT)
          next_brk_cnt = brk_cnt + 8'h01;
      end
      default: next_brk_st = BRK_IDLE;
    endcase
  end

  // tx, baud, break state and registered side outputs
  always_ff @(posedge MCLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      tcnt             <= 5'h00;
      nco              <= 24'h000000;
      ntick            <= 1'b0;
      bcnt             <= 16'hffff;
      BAUD_TICK_OUT    <= 1'b0;
      BAUD_LEVEL_OUT   <= 1'b0;
      brk_st           <= BRK_IDLE;
      brk_cnt          <= 8'h00;
      RX_PUSH_OUT      <= 1'b0;
      RX_ZERO_LOAD_OUT <= 1'b0;
      RX_RESYNC_OUT    <= 1'b0;
      RX_ENABLE_OUT    <= 1'b0;
      FIFO_MODE_OUT    <= 1'b0;
      RLS_IRQ_OUT      <= 1'b0;
      TXE_IRQ_OUT      <= 1'b0;
    end else begin
      tcnt             <= next_tcnt;
      nco              <= next_nco;
      ntick            <= next_ntick;
      bcnt             <= next_bcnt;
      BAUD_TICK_OUT    <= next_btick;
      BAUD_LEVEL_OUT   <= next_level;
      brk_st           <= next_brk_st;
      brk_cnt          <= next_brk_cnt;
      RX_PUSH_OUT      <= push && !brk_load;
      RX_ZERO_LOAD_OUT <= brk_load;
      RX_RESYNC_OUT    <= RX_CHAR_DONE_IN && RX_FERR_IN;
      RX_ENABLE_OUT    <= next_brk_st != BRK_WAIT;
      FIFO_MODE_OUT    <= cfg[`ULSBG_CFG_FIFO];
      RLS_IRQ_OUT      <= RLS_IE_IN && line_val[4:1] != 4'h0;
      TXE_IRQ_OUT      <= TXE_IE_IN && tx_holding_empty;
    end
  end

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!rst_n);

  a_ovr_fifo_full: assert property (
    cfg[0] && RX_CHAR_DONE_IN && !brk_load && cnt == 5'h10 && !RX_POP_IN
    |=> ovr && cnt == 5'h10 && !RX_PUSH_OUT)
    else $error("queue overrun not flagged");
  a_ovr_read_clear: assert property (
    line_rd && !ovr_set |=> !ovr)
    else $error("overrun survived status read");
  a_ready_on_load: assert property (
    !cfg[0] && load |=> line_val[0])
    else $error("data ready missing after load");
  a_break_once: assert property (
    brk_load |=> brk_st == BRK_WAIT ##1 !brk_load)
    else $error("break loaded twice");
  a_idle_restart: assert property (
    brk_st == BRK_WAIT && !rx_s |=> brk_st == BRK_WAIT && !RX_ENABLE_OUT)
    else $error("restart before idle");
  a_hold_write: assert property (
    TX_WRITE_IN && !TX_MOVE_IN && tx_holding_empty
    |=> !tx_holding_empty [*2] or TX_MOVE_IN)
    else $error("holding empty not cleared");
  a_all_empty: assert property (
    line_val[6] |-> line_val[5] && !TX_SHIFT_BUSY_IN)
    else $error("transmitter empty while busy");
  a_modem_zero: assert property (
    acc && !PWRITE_IN && idx == `ULSBG_IDX_MODEM |-> PRDATA_OUT == 32'h0)
    else $error("modem state not zero");
  a_div_reload: assert property (
    div_wr ##1 ntick |=> bcnt == per - 16'h0001 && BAUD_TICK_OUT)
    else $error("divider not reloaded");
  a_bit7_mode: assert property (
    !cfg[0] |=> !err_any)
    else $error("error summary outside queue mode");
  a_rls_request: assert property (
    RLS_IE_IN && ovr |=> RLS_IRQ_OUT)
    else $error("line status request missing");

  c_break_seen:  cover property (brk_load ##[1:400] RX_ENABLE_OUT);
  c_fifo_ovr:    cover property (cfg[0] && ovr_set);
  c_err_read:    cover property (line_rd && line_val[7]);

endmodule : ulsbg_top
`default_nettype wire

// ---- bench/ulsbg_term_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// far-end terminal: marks when idle, holds spacing while asked to
module ulsbg_term_model (
  input  wire logic clk_in,  // bench clock
  input  wire logic brk_in,  // hold the line in spacing
  output logic      rxd_out  // serial line into the device
);
  // spacing lasts as long as asked, far past one frame, then the line
  // returns to marking and stays there, giving the idle gap
  always @(posedge clk_in) begin
    rxd_out <= ~brk_in;
  end
endmodule : ulsbg_term_model
`default_nettype wire

// ---- bench/uart_line_status_and_baud_gen_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module uart_line_status_and_baud_gen_tb_top;
  import ulsbg_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, dacc = 1'b0, paren = 1'b0, rlsie = 1'b1;
  logic        thrie = 1'b1, cd = 1'b0, perr = 1'b0, ferr = 1'b0;
  logic        lvl, lvl_q = 1'b0;
  logic        pop = 1'b0, txw = 1'b0, txm = 1'b0, busy = 1'b0;
  logic        brk = 1'b0;
  logic [1:0]  wl = 2'h0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic        prdy, slverr, rxd, push, zl, rsy, rxen, fm, tick;
  logic        rlsirq, threirq, er;
  int          mismatches = 0, checks_done = 0;
  int          push_cnt = 0, zl_cnt = 0, tick_cnt = 0, rise_cnt = 0;

  always #10 clk = ~clk;

  ulsbg_term_model term (.clk_in(clk), .brk_in(brk), .rxd_out(rxd));

  ulsbg_top dut (
    .MCLK_IN(clk), .NRST_IN(nrst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(prdy), .PSLVERR_OUT(slverr), .RXD_IN(rxd),
    .DIV_ACCESS_IN(dacc), .WORD_LEN_IN(wl), .PARITY_EN_IN(paren),
    .RLS_IE_IN(rlsie), .TXE_IE_IN(thrie), .RX_CHAR_DONE_IN(cd),
    .RX_PERR_IN(perr), .RX_FERR_IN(ferr), .RX_POP_IN(pop),
    .TX_WRITE_IN(txw), .TX_MOVE_IN(txm), .TX_SHIFT_BUSY_IN(busy),
    .RX_PUSH_OUT(push), .RX_ZERO_LOAD_OUT(zl), .RX_RESYNC_OUT(rsy),
    .RX_ENABLE_OUT(rxen), .FIFO_MODE_OUT(fm), .BAUD_TICK_OUT(tick),
    .BAUD_LEVEL_OUT(lvl), .RLS_IRQ_OUT(rlsirq), .TXE_IRQ_OUT(threirq));

  // event counters sampled on the edge, so a one-cycle pulse counts once
  always @(posedge clk) begin
    if (push === 1'b1) push_cnt++;
    if (zl === 1'b1) zl_cnt++;
    if (tick === 1'b1) tick_cnt++;
    if (lvl === 1'b1 && lvl_q === 1'b0) rise_cnt++;
    lvl_q <= lvl;
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'b1 && n < 20);
    rd = prd;
    er = slverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) mismatches++;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rdc

  task automatic rx_char(input logic p, input logic f);
    @(posedge clk);
    cd <= 1'b1;
    perr <= p;
    ferr <= f;
    @(posedge clk);
    cd <= 1'b0;
    perr <= 1'b0;
    ferr <= 1'b0;
    #1;
  endtask : rx_char

  task automatic rx_pop;
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
  endtask : rx_pop

  task automatic set_div(input logic [15:0] dv);
    dacc <= 1'b1;
    apb(1'b1, 8'h00, {24'h0, dv[7:0]});
    apb(1'b1, 8'h04, {24'h0, dv[15:8]});
    dacc <= 1'b0;
  endtask : set_div

  task automatic t_regs;
    rdc(8'h14, 32'h60, "status reset");
    rdc(8'h18, 32'h00, "modem reset");
    dacc <= 1'b1;
    rdc(8'h00, 32'h0c, "divisor low");
    rdc(8'h04, 32'h00, "divisor high");
    dacc <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk("divisor closed", 1'b1, er);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 1'b1, er);
    apb(1'b1, 8'h1c, 32'ha5);
    rdc(8'h1c, 32'ha5, "scratch");
    apb(1'b1, 8'h18, 32'hff);
    rdc(8'h18, 32'h00, "modem write");
    apb(1'b1, 8'h14, 32'h00);
    rdc(8'h14, 32'h60, "status write");
    $display("test regs done");
  endtask : t_regs

  task automatic t_tx;
    chk("tx_holding_empty irq idle", 1'b1, threirq);
    @(posedge clk);
    txw <= 1'b1;
    @(posedge clk);
    txw <= 1'b0;
    rdc(8'h14, 32'h00, "holding full");
    chk("tx_holding_empty irq off", 1'b0, threirq);
    busy <= 1'b1;
    @(posedge clk);
    txm <= 1'b1;
    @(posedge clk);
    txm <= 1'b0;
    rdc(8'h14, 32'h20, "shifter busy");
    busy <= 1'b0;
    rdc(8'h14, 32'h60, "all empty");
    chk("tx_holding_empty irq back", 1'b1, threirq);
    $display("test tx done");
  endtask : t_tx

  // ticks in 2000 cycles: source / divisor (0 taken as 3); level rises the same but half at divisor 1; within two
  task automatic t_baud;
    int exp [7] = '{74, 74, 147, 295, 37, 25, 25};
    int rexp [7] = '{37, 37, 74, 147, 37, 25, 25};
    int t0;
    int r0;
    int d;
    for (int i = 0; i < 7; i++) begin
      set_div(i == 4 ? 16'h2 : (i == 5 ? 16'h0
              : (i == 6 ? 16'h3 : 16'h1)));
      apb(1'b1, 8'h20, {29'h0, i < 4 ? i[1:0] : 2'h0, 1'b0});
      repeat (20) @(posedge clk);
      t0 = tick_cnt;
      r0 = rise_cnt;
      repeat (2000) @(posedge clk);
      d = tick_cnt - t0 - exp[i];
      chk("tick rate", 1'b1, d inside {[-2:2]});
      d = rise_cnt - r0 - rexp[i];
      chk("level rate", 1'b1, d inside {[-2:2]});
    end
    set_div(16'h1);
    $display("test baud done");
  endtask : t_baud

  task automatic t_rx;
    rx_char(1'b1, 1'b0);
    chk("push", 1'b1, push);
    rdc(8'h14, 32'h65, "parity");
    chk("rls irq", 1'b1, rlsirq);
    rdc(8'h14, 32'h61, "parity clear");
    chk("rls irq off", 1'b0, rlsirq);
    rx_pop;
    rdc(8'h14, 32'h60, "drained");
    rx_char(1'b0, 1'b0);
    rx_char(1'b0, 1'b0);
    rdc(8'h14, 32'h63, "overrun");
    rdc(8'h14, 32'h61, "overrun clear");
    rx_pop;
    rx_char(1'b0, 1'b1);
    chk("resync", 1'b1, rsy);
    rdc(8'h14, 32'h69, "framing");
    rdc(8'h14, 32'h61, "framing clear");
    rx_pop;
    $display("test rx done");
  endtask : t_rx

  task automatic t_break;
    int n;
    int z0;
    int p0;
    z0 = zl_cnt;
    p0 = push_cnt;
    n = 0;
    brk <= 1'b1;
    while (zl_cnt == z0 && n < 8000) begin
      @(posedge clk);
      n++;
    end
    repeat (4000) @(posedge clk);
    chk("zero loads", 32'd1, zl_cnt - z0);
    chk("no push", 32'd0, push_cnt - p0);
    chk("rx gated", 1'b0, rxen);
    apb(1'b0, 8'h14, 32'h0);
    chk("break flag", 1'b1, rd[4]);
    brk <= 1'b0;
    repeat (6) @(posedge clk);
    chk("still gated", 1'b0, rxen);
    n = 0;
    while (rxen !== 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    chk("rx restart", 1'b1, rxen);
    rx_pop;
    $display("test break done");
  endtask : t_break

  task automatic t_fifo;
    int p0;
    apb(1'b1, 8'h20, 32'h1);
    repeat (2) @(posedge clk);
    chk("queue mode", 1'b1, fm);
    p0 = push_cnt;
    @(posedge clk);
    cd <= 1'b1;
    perr <= 1'b1;
    @(posedge clk);
    perr <= 1'b0;
    repeat (16) @(posedge clk);
    cd <= 1'b0;
    repeat (2) @(posedge clk);
    chk("queued", 32'd16, push_cnt - p0);
    rdc(8'h14, 32'he7, "queue full");
    rx_pop;
    rdc(8'h14, 32'he1, "head popped");
    repeat (15) rx_pop;
    rdc(8'h14, 32'h60, "queue empty");
    $display("test fifo done");
  endtask : t_fifo

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // whole run needs about 22000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    report_and_stop;
  end

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs;
    t_tx;
    t_baud;
    t_rx;
    t_break;
    t_fifo;
    report_and_stop;
  end
endmodule : uart_line_status_and_baud_gen_tb_top
`default_nettype wire
